// ---- src/dtc_top.sv ----
// Two timer/counters with four modes, flags, gating and baud overflow output.
// How it works
// - In modes 0 and 1 low count overflow bumps high byte; high byte overflow sets the flag.
// - Run bit does not clear counts; counts read live and preset by writes.
// - Timer source advances once per peripheral cycle of six clocks.
// - Counter source counts a high sample followed by a low sample.
// - Edge detection spans two peripheral cycles, limiting rate to clock/12.
// - Gate clear means run bit alone enables; gate set adds the pin.
// - Gated counting needs the interrupt pin high and run set.
// - Timer 0 uses low mode nibble; timer 1 uses high nibble.
// - Mode codes 00 13-bit, 01 16-bit, 10 reload, 11 mode 3.
// - Rollover from all ones to zero sets the overflow flag, except timer 1 while timer 0 is in mode 3.
// - Mode 0: five-bit prescaler in low byte feeds eight-bit high byte.
// - Mode 1: full 16-bit cascade, input advances low byte.
// - Mode 2: low byte reloads from high byte on overflow, flag set.
// - Flag clears when the processor vectors to the timer's routine.
// - Mode 3: timer 0 high byte counts cycles using timer 1 run and flag.
// - Timer 1 mode 3 halts and holds its count.
// - Request forwarded only with per-timer and global enables set.
// - Timer 1 overflow drives the serial baud output.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_top
  import dtc_pkg::*;
(
  input wire logic clk_in, // Peripheral clock.
  input wire logic rst_in, // Asynchronous reset, high.
  input wire logic [7:0] timer_mode_register_in, // Gate, source and mode of both timers.
  input wire logic timer0_run_in, // Timer 0 run bit.
  input wire logic timer1_run_in, // Timer 1 run bit.
  input wire logic timer0_count_pin_in, // External count pin of timer 0.
  input wire logic timer1_count_pin_in, // External count pin of timer 1.
  input wire logic ext_irq0_pin_in, // Gate pin of timer 0.
  input wire logic ext_irq1_pin_in, // Gate pin of timer 1.
  input dtc_pkg::dtc_wr_type timer0_wr_in, // Preset of timer 0 bytes.
  input dtc_pkg::dtc_wr_type timer1_wr_in, // Preset of timer 1 bytes.
  input wire logic timer0_vector_in, // Processor vectors to timer 0 routine.
  input wire logic timer1_vector_in, // Processor vectors to timer 1 routine.
  input wire logic [1:0] timer_irq_enable_in, // Per-timer interrupt enables.
  input wire logic global_irq_enable_in, // Global interrupt enable.
  output logic [7:0] timer0_high_byte_out, // Live timer 0 high byte.
  output logic [7:0] timer0_low_byte_out, // Live timer 0 low byte.
  output logic [7:0] timer1_high_byte_out, // Live timer 1 high byte.
  output logic [7:0] timer1_low_byte_out, // Live timer 1 low byte.
  output logic timer0_overflow_flag_out, // Timer 0 overflow flag.
  output logic timer1_overflow_flag_out, // Timer 1 overflow flag.
  output logic [1:0] timer_irq_out, // Enabled interrupt requests.
  output logic baud_overflow_out // Timer 1 overflow pulse for baud logic.
);
  logic cycle;
  logic fall0;
  logic fall1;
  dtc_cfg_type cfg0;
  dtc_cfg_type cfg1;
  logic [7:0] th0_r, tl0_r, th1_r, tl1_r;
  logic [7:0] th0_nxt, tl0_nxt, th1_nxt, tl1_nxt;
  logic tf0_r, tf1_r, tf0_nxt, tf1_nxt;
  logic [1:0] irq_r, irq_nxt;
  logic baud_r, baud_nxt;
  logic split;
  logic en0, en1, en0h;
  logic ov0, ov1, ov0h;

  dtc_cycle_gen #(.DIV(`DTC_PER_DIV)) u_cycle (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cycle_out(cycle)
  );
  dtc_edge_det u_edge0 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cycle_in(cycle),
    .pin_in(timer0_count_pin_in),
    .fall_out(fall0)
  );
  dtc_edge_det u_edge1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cycle_in(cycle),
    .pin_in(timer1_count_pin_in),
    .fall_out(fall1)
  );

  // gate enable: gate set needs pin high too.
  function automatic logic count_enable(input dtc_cfg_type c, input logic run, input logic pin,
                                        input logic cyc, input logic fall);
    logic tick;
    tick = c.source_select ? fall : cyc;
    count_enable = tick & run & (~c.gate_select | pin);
  endfunction : count_enable

  // One count step in all four modes, mode 3 for timer 0 only; returns overflow.
  function automatic logic [16:0] step(input logic [1:0] mode, input logic [7:0] th, input logic [7:0] tl);
    logic [16:0] r;
    r = {1'b0, th, tl};
    unique case (mode)
      `DTC_MODE_13BIT: begin
        if (tl[4:0] == 5'h1f) begin
          r = {(th == 8'hff), th + 8'h01, tl[7:5], 5'h00};
        end else begin
          r = {1'b0, th, tl[7:5], tl[4:0] + 5'h01};
        end
      end
      `DTC_MODE_16BIT: r = {1'b0, th, tl} + 17'h00001;
      `DTC_MODE_RELOAD: r = (tl == 8'hff) ? {1'b1, th, th} : {1'b0, th, tl + 8'h01};
      `DTC_MODE_SPLIT: r = {(tl == 8'hff), th, tl + 8'h01};
    endcase
    step = r;
  endfunction : step

  assign cfg0 = timer_mode_register_in[`DTC_T0_FIELD_LSB +: 4];
  assign cfg1 = timer_mode_register_in[`DTC_T1_FIELD_LSB +: 4];
  assign split = (cfg0.mode == `DTC_MODE_SPLIT);
  assign en0 = count_enable(cfg0, timer0_run_in, ext_irq0_pin_in, cycle, fall0);
  // split high byte uses timer 1 run, cycle source, no gate.
  assign en0h = split & timer1_run_in & cycle;
  // timer 1 halts only in its own mode 3; under split its run bit belongs to timer 0.
  assign en1 = (cfg1.mode != `DTC_MODE_SPLIT) & count_enable(cfg1, timer1_run_in | split, ext_irq1_pin_in, cycle, fall1);

  // Next counts of both timers. A software preset overrides counting that cycle.
  always_comb begin
    logic [16:0] s0;
    logic [16:0] s1;
    s0 = 17'h00000;
    s1 = 17'h00000;
    th0_nxt = th0_r;
    tl0_nxt = tl0_r;
    th1_nxt = th1_r;
    tl1_nxt = tl1_r;
    ov0 = 1'b0;
    ov0h = 1'b0;
    ov1 = 1'b0;
    if (en0) begin
      s0 = step(cfg0.mode, th0_r, tl0_r);
      ov0 = s0[16];
      tl0_nxt = s0[7:0];
      if (!split) begin
        th0_nxt = s0[15:8];
      end
    end
    if (en0h) begin
      th0_nxt = th0_r + 8'h01;
      ov0h = (th0_r == 8'hff);
    end
    if (en1) begin
      s1 = step(cfg1.mode, th1_r, tl1_r);
      ov1 = s1[16];
      th1_nxt = s1[15:8];
      tl1_nxt = s1[7:0];
    end
    if (timer0_wr_in.high_we) th0_nxt = timer0_wr_in.data;
    if (timer0_wr_in.low_we) tl0_nxt = timer0_wr_in.data;
    if (timer1_wr_in.high_we) th1_nxt = timer1_wr_in.data;
    if (timer1_wr_in.low_we) tl1_nxt = timer1_wr_in.data;
  end

  // Flags, requests and baud pulse.
  always_comb begin
    // flag set wins over vector clear
    tf0_nxt = ov0 | (tf0_r & ~timer0_vector_in);
    // split mode: timer 0 high byte owns flag 1
    tf1_nxt = (split ? ov0h : ov1) | (tf1_r & ~timer1_vector_in);
    irq_nxt = {tf1_nxt, tf0_nxt} & timer_irq_enable_in & {2{global_irq_enable_in}};
    baud_nxt = ov1;
  end

  // Register all state.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      th0_r <= `DTC_COUNT_RESET;
      tl0_r <= `DTC_COUNT_RESET;
      th1_r <= `DTC_COUNT_RESET;
      tl1_r <= `DTC_COUNT_RESET;
      tf0_r <= 1'b0;
      tf1_r <= 1'b0;
      irq_r <= 2'h0;
      baud_r <= 1'b0;
    end else begin
      th0_r <= th0_nxt;
      tl0_r <= tl0_nxt;
      th1_r <= th1_nxt;
      tl1_r <= tl1_nxt;
      tf0_r <= tf0_nxt;
      tf1_r <= tf1_nxt;
      irq_r <= irq_nxt;
      baud_r <= baud_nxt;
    end
  end

  assign timer0_high_byte_out = th0_r;
  assign timer0_low_byte_out = tl0_r;
  assign timer1_high_byte_out = th1_r;
  assign timer1_low_byte_out = tl1_r;
  assign timer0_overflow_flag_out = tf0_r;
  assign timer1_overflow_flag_out = tf1_r;
  assign timer_irq_out = irq_r;
  assign baud_overflow_out = baud_r;

  // Checks.
  // Any software write to timer 0 bytes; such a cycle is exempt from the count checks.
  logic wr0_any;
  assign wr0_any = timer0_wr_in.high_we | timer0_wr_in.low_we;

  property p_flag0_set;
    @(posedge clk_in) disable iff (rst_in) ov0 |=> tf0_r;
  endproperty
  a_flag0_set: assert property (p_flag0_set) else $error("timer 0 flag not set on overflow");
  property p_flag_clear;
    @(posedge clk_in) disable iff (rst_in) (timer0_vector_in && !ov0) |=> !tf0_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("timer 0 flag not cleared on vector");
  property p_hold1;
    @(posedge clk_in) disable iff (rst_in)
      (cfg1.mode == `DTC_MODE_SPLIT && !timer1_wr_in.high_we && !timer1_wr_in.low_we)
      |=> $stable(tl1_r) && $stable(th1_r);
  endproperty
  a_hold1: assert property (p_hold1) else $error("timer 1 count moved in hold mode");
  property p_gate;
    @(posedge clk_in) disable iff (rst_in)
      (cfg0.gate_select && !ext_irq0_pin_in && !split && !timer0_wr_in.low_we) |=> $stable(tl0_r);
  endproperty
  a_gate: assert property (p_gate) else $error("timer 0 counted with gate pin low");
  property p_reload;
    @(posedge clk_in) disable iff (rst_in)
      (en0 && cfg0.mode == `DTC_MODE_RELOAD && tl0_r == 8'hff && !timer0_wr_in.low_we)
      |=> (tl0_r == $past(th0_r)) && tf0_r;
  endproperty
  a_reload: assert property (p_reload) else $error("reload failed");
  property p_rate;
    @(posedge clk_in) disable iff (rst_in) cycle |=> !cycle [*5] ##1 cycle;
  endproperty
  a_rate: assert property (p_rate) else $error("peripheral cycle not six clocks");
  property p_irq;
    @(posedge clk_in) disable iff (rst_in) !global_irq_enable_in |=> timer_irq_out == 2'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("request passed with global enable clear");
  property p_baud;
    @(posedge clk_in) disable iff (rst_in) ov1 |=> baud_overflow_out;
  endproperty
  a_baud: assert property (p_baud) else $error("baud pulse missing");
  property p_split_flag;
    @(posedge clk_in) disable iff (rst_in) (split && ov1 && !ov0h && !tf1_r) |=> !tf1_r;
  endproperty
  a_split_flag: assert property (p_split_flag) else $error("timer 1 set flag in split mode");
  property p_cascade;
    @(posedge clk_in) disable iff (rst_in)
      (en0 && cfg0.mode == `DTC_MODE_16BIT && tl0_r == 8'hff && !wr0_any) |=> th0_r == $past(th0_r) + 8'h01;
  endproperty
  a_cascade: assert property (p_cascade) else $error("low byte carry lost");
  property p_prescale;
    @(posedge clk_in) disable iff (rst_in)
      (en0 && cfg0.mode == `DTC_MODE_13BIT && tl0_r[4:0] == 5'h1f && !wr0_any)
      |=> (tl0_r[4:0] == 5'h00) && (th0_r == $past(th0_r) + 8'h01);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler carry lost");
  property p_stopped;
    @(posedge clk_in) disable iff (rst_in)
      (!timer0_run_in && !split && !wr0_any) |=> $stable(tl0_r) && $stable(th0_r);
  endproperty
  a_stopped: assert property (p_stopped) else $error("timer 0 moved with run bit clear");
  property p_fall;
    @(posedge clk_in) disable iff (rst_in) fall0 |-> $past(cycle) && !$past(timer0_count_pin_in);
  endproperty
  a_fall: assert property (p_fall) else $error("count pin fall without a low sample");
  property p_split_high;
    @(posedge clk_in) disable iff (rst_in) (en0h && th0_r == 8'hff) |=> tf1_r;
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high byte overflow lost");
  property p_irq_follow;
    @(posedge clk_in) disable iff (rst_in)
      (global_irq_enable_in && timer_irq_enable_in[0]) |=> timer_irq_out[0] == timer0_overflow_flag_out;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("enabled request differs from flag");
  property p_baud_width;
    @(posedge clk_in) disable iff (rst_in) baud_overflow_out |=> !baud_overflow_out;
  endproperty
  a_baud_width: assert property (p_baud_width) else $error("baud pulse wider than one cycle");

  // Main scenarios: overflow, split high byte, baud, reload and gated counting.
  c_overflow0: cover property (@(posedge clk_in) disable iff (rst_in) ov0);
  c_split_high: cover property (@(posedge clk_in) disable iff (rst_in) ov0h);
  c_baud: cover property (@(posedge clk_in) disable iff (rst_in) baud_overflow_out);
  c_reload: cover property (@(posedge clk_in) disable iff (rst_in)
    en0 && cfg0.mode == `DTC_MODE_RELOAD && tl0_r == 8'hff);
  c_gated_count: cover property (@(posedge clk_in) disable iff (rst_in)
    en0 && cfg0.gate_select);
endmodule : dtc_top

// ---- src/dtc_cfg.svh ----
// Constants for the dual timer/counter: field positions, reset values and timing counts.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
`define DTC_PER_DIV 6
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3
`define DTC_PRESCALE_BITS 5
`define DTC_MODE_RESET 8'h00
`define DTC_COUNT_RESET 8'h00
`define DTC_T0_FIELD_LSB 0
`define DTC_T1_FIELD_LSB 4
`define DTC_CTL_T0_RUN 4
`define DTC_CTL_T0_FLAG 5
`define DTC_CTL_T1_RUN 6
`define DTC_CTL_T1_FLAG 7
`endif

// ---- src/dtc_pkg.sv ----
// Types shared by the dual timer/counter files.
package dtc_pkg;
  // Per-timer fields of the mode register.
  typedef struct packed {
    logic gate_select;
    logic source_select;
    logic [1:0] mode;
  } dtc_cfg_type;
  // Software preset of one count byte.
  typedef struct packed {
    logic high_we;
    logic low_we;
    logic [7:0] data;
  } dtc_wr_type;
endpackage : dtc_pkg

// ---- src/dtc_cycle_gen.sv ----
// Peripheral cycle enable divider.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_cycle_gen #(
  parameter int DIV = `DTC_PER_DIV
) (
  input wire logic clk_in, // Peripheral clock.
  input wire logic rst_in, // Asynchronous reset, high.
  output logic cycle_out // One pulse per peripheral cycle.
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic cycle_r;
  logic cycle_nxt;

  // Count DIV clocks and pulse on the last.
  always_comb begin
    cycle_nxt = (cnt_r == 4'(DIV - 1));
    cnt_nxt = cycle_nxt ? 4'h0 : cnt_r + 4'h1;
  end

  // Register the divider state.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 4'h0;
      cycle_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      cycle_r <= cycle_nxt;
    end
  end
  assign cycle_out = cycle_r;
endmodule : dtc_cycle_gen

// ---- src/dtc_edge_det.sv ----
// Falling edge sampler for an external count pin.
`timescale 1ns/1ps
module dtc_edge_det (
  input wire logic clk_in, // Peripheral clock.
  input wire logic rst_in, // Asynchronous reset, high.
  input wire logic cycle_in, // Peripheral cycle enable.
  input wire logic pin_in, // External count pin.
  output logic fall_out // One pulse per detected fall.
);
  logic prev_r;
  logic prev_nxt;
  logic fall_r;
  logic fall_nxt;

  // Sample once per peripheral cycle; a high sample then low sample is one count.
  always_comb begin
    prev_nxt = cycle_in ? pin_in : prev_r;
    fall_nxt = cycle_in & prev_r & ~pin_in;
  end

  // Register sample and pulse.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      fall_r <= fall_nxt;
    end
  end
  assign fall_out = fall_r;
endmodule : dtc_edge_det

// ---- bench/dtc_pin_model.sv ----
// Model of the external count and gate pins of both timers.
`timescale 1ns/1ps
module dtc_pin_model (
  input wire logic clk_in, // Peripheral clock.
  input wire logic toggle_in, // Run the square wave on the count pins.
  input wire logic [1:0] gate_in, // Wanted gate pin levels.
  output logic [1:0] count_pin_out, // Count pins of both timers.
  output logic [1:0] gate_pin_out // Gate pins of both timers.
);
  int ph = 0;
  // levels held six clocks
  // Each level lasts one whole peripheral cycle, so no level can slip between two samples.
  always @(negedge clk_in) begin
    ph <= (ph == 11) ? 0 : ph + 1;
    count_pin_out <= (toggle_in && ph >= 6) ? 2'h0 : 2'h3;
  end
  // Gate pins are plain levels set by the bench.
  assign gate_pin_out = gate_in;
endmodule : dtc_pin_model

// ---- bench/dtc_top_tb_top.sv ----
// Self-checking bench for the dual timer/counter.
`timescale 1ns/1ps
module dtc_top_tb_top;
  import dtc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] mode = 8'h00;
  logic run0 = 1'b0;
  logic run1 = 1'b0;
  logic tog = 1'b0;
  logic [1:0] gate = 2'h0;
  logic [1:0] cpin;
  logic [1:0] gpin;
  dtc_wr_type w [2] = '{default: '0};
  logic vec0 = 1'b0;
  logic vec1 = 1'b0;
  logic [1:0] ien = 2'h0;
  logic gie = 1'b0;
  logic [7:0] th0, tl0, th1, tl1;
  logic f0, f1, bd;
  logic [1:0] irq;
  logic [15:0] a;
  logic [31:0] d;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int bauds = 0;
  always #2 clk = ~clk;
  dtc_pin_model pin_u (.clk_in(clk), .toggle_in(tog), .gate_in(gate), .count_pin_out(cpin), .gate_pin_out(gpin));
  dtc_top dut_u (.clk_in(clk), .rst_in(rst), .timer_mode_register_in(mode), .timer0_run_in(run0),
    .timer1_run_in(run1), .timer0_count_pin_in(cpin[0]), .timer1_count_pin_in(cpin[1]),
    .ext_irq0_pin_in(gpin[0]), .ext_irq1_pin_in(gpin[1]), .timer0_wr_in(w[0]), .timer1_wr_in(w[1]),
    .timer0_vector_in(vec0), .timer1_vector_in(vec1), .timer_irq_enable_in(ien),
    .global_irq_enable_in(gie), .timer0_high_byte_out(th0), .timer0_low_byte_out(tl0),
    .timer1_high_byte_out(th1), .timer1_low_byte_out(tl1), .timer0_overflow_flag_out(f0),
    .timer1_overflow_flag_out(f1), .timer_irq_out(irq), .baud_overflow_out(bd));
  // Compare one value and count the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic go(input int n);
    repeat (n) @(negedge clk);
  endtask : go
  // Preset both count bytes of one timer, high byte first, one write a cycle.
  task automatic preset(input int t, input logic [7:0] hi, input logic [7:0] lo);
    go(1);
    w[t] = '{1'b1, 1'b0, hi};
    go(1);
    w[t] = '{1'b0, 1'b1, lo};
    go(1);
    w[t] = '0;
  endtask : preset
  // Count progress over a fixed span; a span of whole periods makes the figure exact.
  task automatic delta(input int t, input int clocks, output logic [31:0] dd);
    a = t ? {th1, tl1} : {th0, tl0};
    go(clocks);
    dd = {16'h0000, (t ? {th1, tl1} : {th0, tl0}) - a};
  endtask : delta
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // Baud pulses are one cycle wide, so they are counted at every edge.
  always @(posedge clk) begin
    if (bd === 1'b1) begin
      bauds++;
    end
  end
  // Cut a hang short; the tests need about a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    go(8);
    rst = 1'b0;
    go(2);
    chk({th0, tl0, th1, tl1}, 32'h0);
    chk({f0, f1, irq, bd}, 32'h0);
    $display("test reset done");
    mode = 8'h01;
    preset(0, 8'hff, 8'hf0);
    go(1);
    chk({th0, tl0}, 32'hfff0);
    run0 = 1'b1;
    delta(0, 60, d);
    chk(d, 32'ha);
    chk(th0, 32'hff);
    go(60);
    chk({f0, th0}, 32'h100);
    chk(irq, 32'h0);
    ien = 2'h1;
    go(2);
    chk(irq, 32'h0);
    gie = 1'b1;
    go(2);
    chk(irq, 32'h1);
    vec0 = 1'b1;
    go(1);
    vec0 = 1'b0;
    go(1);
    chk({f0, irq}, 32'h0);
    $display("test cascade done");
    run0 = 1'b0;
    go(1);
    mode = 8'h00;
    preset(0, 8'h10, 8'h00);
    run0 = 1'b1;
    go(195);
    chk({th0, tl0[4:1]}, 32'h110);
    run0 = 1'b0;
    go(1);
    mode = 8'h02;
    preset(0, 8'hf0, 8'hfc);
    run0 = 1'b1;
    go(27);
    chk({f0, th0, tl0[7:1]}, {1'b1, 8'hf0, 7'h78});
    run0 = 1'b0;
    $display("test prescale and reload done");
    mode = 8'h05;
    tog = 1'b1;
    go(24);
    run0 = 1'b1;
    delta(0, 120, d);
    chk(d, 32'ha);
    tog = 1'b0;
    run0 = 1'b0;
    go(1);
    mode = 8'h09;
    go(1);
    run0 = 1'b1;
    delta(0, 60, d);
    chk(d, 32'h0);
    gate = 2'h1;
    delta(0, 60, d);
    chk(d, 32'ha);
    run0 = 1'b0;
    delta(0, 60, d);
    chk(d, 32'h0);
    $display("test counter and gate done");
    // timer 1 halted by mode 3
    mode = 8'h31;
    preset(1, 8'h12, 8'h34);
    run1 = 1'b1;
    go(60);
    chk({th1, tl1}, 32'h1234);
    run1 = 1'b0;
    go(1);
    // preset while timer 1 is held and the split high byte is stopped
    mode = 8'h33;
    preset(1, 8'hff, 8'hff);
    preset(0, 8'h00, 8'h00);
    mode = 8'h23;
    run1 = 1'b1;
    bauds = 0;
    go(60);
    chk(bauds, 32'ha);
    chk({th0, tl0, f1}, {8'h0a, 8'h00, 1'b0});
    // Under split the run bit stops only the high byte of timer 0.
    run1 = 1'b0;
    bauds = 0;
    go(60);
    chk(bauds, 32'ha);
    chk(th0, 32'h0a);
    preset(0, 8'hff, 8'h00);
    run1 = 1'b1;
    go(12);
    chk({f1, th0}, {1'b1, 8'h01});
    vec1 = 1'b1;
    go(1);
    vec1 = 1'b0;
    go(1);
    chk(f1, 32'h0);
    // timer 1 stopped again by its mode 3
    mode = 8'h33;
    go(1);
    bauds = 0;
    go(60);
    chk(bauds, 32'h0);
    $display("test split done");
    tally_and_finish();
  end
endmodule : dtc_top_tb_top
